/* File: wwrpe_pkg.sv */
// Shared constants, types and helpers for the window watchdog and port entry block
package wwrpe_pkg;

	// System clock and the internal oscillator rate
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
	localparam int unsigned OSC_HZ = 128000;
	localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
	// One millisecond in system cycles
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYC = MS_NS / CLK_NS;

	// Window for the transmit line to fall after the enable falling edge
	localparam int unsigned PORT_ENTRY_MIN_NS = 2000;
	localparam int unsigned PORT_ENTRY_MAX_NS = 10000;
	localparam logic [7:0] PORT_ENTRY_MIN_CYC = 8'((PORT_ENTRY_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] PORT_ENTRY_MAX_CYC = 8'(PORT_ENTRY_MAX_NS / CLK_NS);
	localparam logic [7:0] CYC_SAT = 8'hFF;
	// Oscillator cycles with the transmit line high before low power entry
	localparam logic [2:0] STANDBY_ENTRY_TICKS = 3'h5;
	// Oscillator cycles with both lines idle high before the port closes
	localparam logic [2:0] PORT_IDLE_TICKS = 3'h2;

	// Nominal window lengths and the shutdown reset time, in ms
	localparam logic [9:0] EARLY_WINDOW_MS = 10'h064;
	localparam logic [9:0] SERVICE_WINDOW_MS = 10'h064;
	localparam logic [9:0] SHUTDOWN_RESET_MS = 10'h1F4;

	// Factory scaling of the window timings
	typedef enum logic [2:0] {
		SCALE_M40 = 3'h0,
		SCALE_M20 = 3'h1,
		SCALE_NOM = 3'h2,
		SCALE_P20 = 3'h3,
		SCALE_P60 = 3'h4,
		SCALE_P100 = 3'h5
	} wwrpe_scale_t;

	// Factory choice of the reset hold time
	typedef enum logic [1:0] {
		HOLD_4MS = 2'h0,
		HOLD_8MS = 2'h1,
		HOLD_16MS = 2'h2,
		HOLD_32MS = 2'h3
	} wwrpe_hold_t;

	// Build time configuration standing in for factory programming
	localparam wwrpe_scale_t WINDOW_SCALE = SCALE_NOM;
	localparam wwrpe_hold_t RESET_HOLD_SEL = HOLD_8MS;

	// Watchdog states, one-hot
	typedef enum logic [4:0] {
		WD_OFF = 5'h01,
		WD_HOLD = 5'h02,
		WD_EARLY = 5'h04,
		WD_SERV = 5'h08,
		WD_SHUT = 5'h10
	} wwrpe_wd_t;

	// Port entry states, one-hot
	typedef enum logic [3:0] {
		EN_IDLE = 4'h1,
		EN_WAIT = 4'h2,
		EN_PORT = 4'h4,
		EN_DONE = 4'h8
	} wwrpe_entry_t;

	// Pin levels sampled from outside the clock domain
	typedef struct packed {
		logic en;
		logic tx;
		logic supply_ok;
	} wwrpe_pins_t;
	localparam wwrpe_pins_t PINS_RST = 3'h6;

	// Scales a window length by the factory percentage
	function automatic logic [9:0] wwrpe_scale_ms(input logic [9:0] ms, input wwrpe_scale_t sc);
		logic [17:0] prod;
		// Widen before multiplying so the product cannot wrap at ten bits
		case (sc)
			SCALE_M40: prod = 18'(ms) * 18'h0003C;
			SCALE_M20: prod = 18'(ms) * 18'h00050;
			SCALE_P20: prod = 18'(ms) * 18'h00078;
			SCALE_P60: prod = 18'(ms) * 18'h000A0;
			SCALE_P100: prod = 18'(ms) * 18'h000C8;
			default: prod = 18'(ms) * 18'h00064;
		endcase
		return 10'(prod / 18'h00064);
	endfunction : wwrpe_scale_ms

	// Reset hold time in ms for a factory choice
	function automatic logic [9:0] wwrpe_hold_ms(input wwrpe_hold_t sel);
		case (sel)
			HOLD_4MS: return 10'h004;
			HOLD_16MS: return 10'h010;
			HOLD_32MS: return 10'h020;
			default: return 10'h008;
		endcase
	endfunction : wwrpe_hold_ms

endpackage : wwrpe_pkg

/* File: wwrpe_tick.sv */
`timescale 1ns/1ps
// Free running divider giving a one-cycle enable every DIV cycles
module wwrpe_tick #(
	parameter int unsigned DIV = 156
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clr,
	output logic tick_q
);

	logic [15:0] cnt_q; // Cycle count within one period
	logic [15:0] cnt_d;
	logic tick_d;

	// Next count; a clear restarts the period so timing aligns to an event
	always_comb
	begin
		cnt_d = cnt_q + 16'h0001;
		tick_d = 1'b0;
		if (clr)
		begin
			cnt_d = 16'h0000;
		end
		else if (cnt_q == 16'(DIV - 1))
		begin
			cnt_d = 16'h0000;
			tick_d = 1'b1;
		end
	end

	// Counter and enable registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

endmodule : wwrpe_tick

/* File: wwrpe_top.sv */
`timescale 1ns/1ps
module wwrpe_top #(
	parameter int unsigned MS_CYC = wwrpe_pkg::MS_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic supply_ok, // Supply above undervoltage threshold, asynchronous
	input wire logic en_pin, // Shared enable pin
	input wire logic tx_pin, // Shared transmit pin
	input wire logic wd_trigger, // One-cycle watchdog trigger from port logic
	input wire logic shutdown_req, // One-cycle temporary shutdown request
	output logic rst_out_b_q, // Reset to the microcontroller, active low
	output logic service_open_q, // Service window is open
	output logic port_mode_q, // Serial port mode entered
	output logic sleep_req_q // One-cycle request for sleep or standby
);

	// Build time window lengths and reset hold time
	localparam logic [9:0] EARLY_MS = wwrpe_pkg::wwrpe_scale_ms(wwrpe_pkg::EARLY_WINDOW_MS,
		wwrpe_pkg::WINDOW_SCALE);
	localparam logic [9:0] SERV_MS = wwrpe_pkg::wwrpe_scale_ms(wwrpe_pkg::SERVICE_WINDOW_MS,
		wwrpe_pkg::WINDOW_SCALE);
	localparam logic [9:0] HOLD_MS = wwrpe_pkg::wwrpe_hold_ms(wwrpe_pkg::RESET_HOLD_SEL);
	localparam logic [23:0] HOLD_CYC = 24'(HOLD_MS * MS_CYC);

	// Two-stage synchroniser and previous level for edge finding
	wwrpe_pkg::wwrpe_pins_t pins_m_q;
	wwrpe_pkg::wwrpe_pins_t pins_s_q;
	logic en_p_q;
	logic tx_p_q;

	// Synchronise the pins; only the second stage is read by logic
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pins_m_q <= wwrpe_pkg::PINS_RST;
			pins_s_q <= wwrpe_pkg::PINS_RST;
			en_p_q <= 1'b1;
			tx_p_q <= 1'b1;
		end
		else
		begin
			pins_m_q <= '{en: en_pin, tx: tx_pin, supply_ok: supply_ok};
			pins_s_q <= pins_m_q;
			en_p_q <= pins_s_q.en;
			tx_p_q <= pins_s_q.tx;
		end
	end

	logic en_fall; // Enable falling edge seen
	logic tx_fall; // Transmit falling edge seen
	assign en_fall = en_p_q & ~pins_s_q.en;
	assign tx_fall = tx_p_q & ~pins_s_q.tx;

	logic osc_tick; // Oscillator rate enable
	logic ms_tick; // Millisecond enable
	logic restart; // Restart of the window timer

	// Oscillator enable, aligned to each enable falling edge
	wwrpe_tick #(.DIV(wwrpe_pkg::OSC_DIV)) u_osc_tick (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clr(en_fall),
		.tick_q(osc_tick)
	);

	// Millisecond enable, aligned to each window restart
	wwrpe_tick #(.DIV(MS_CYC)) u_ms_tick (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clr(restart),
		.tick_q(ms_tick)
	);

	// Watchdog state
	wwrpe_pkg::wwrpe_wd_t wd_q;
	wwrpe_pkg::wwrpe_wd_t wd_d;
	logic [9:0] ms_q; // Milliseconds elapsed in the current interval
	logic [9:0] ms_d;
	logic [23:0] hold_cyc_q; // Cycles spent holding reset, read by checks only
	logic [23:0] hold_cyc_d;
	logic rst_out_b_d;
	logic service_open_d;

	// Next watchdog state, interval count and outputs
	always_comb
	begin
		wd_d = wd_q;
		restart = 1'b0;
		if (!pins_s_q.supply_ok)
		begin
			wd_d = wwrpe_pkg::WD_OFF;
		end
		else if (shutdown_req && wd_q != wwrpe_pkg::WD_OFF && wd_q != wwrpe_pkg::WD_SHUT)
		begin
			wd_d = wwrpe_pkg::WD_SHUT;
			restart = 1'b1;
		end
		else
		begin
			case (wd_q)
				wwrpe_pkg::WD_OFF:
				begin
					// Supply back: hold reset before the watchdog starts
					wd_d = wwrpe_pkg::WD_HOLD;
					restart = 1'b1;
				end
				wwrpe_pkg::WD_HOLD:
				begin
					if (ms_tick && ms_q == HOLD_MS - 10'h001)
					begin
						wd_d = wwrpe_pkg::WD_EARLY;
						restart = 1'b1;
					end
				end
				wwrpe_pkg::WD_EARLY:
				begin
					if (wd_trigger)
					begin
						wd_d = wwrpe_pkg::WD_HOLD;
						restart = 1'b1;
					end
					else if (ms_tick && ms_q == EARLY_MS - 10'h001)
					begin
						wd_d = wwrpe_pkg::WD_SERV;
						restart = 1'b1;
					end
				end
				wwrpe_pkg::WD_SERV:
				begin
					if (wd_trigger)
					begin
						wd_d = wwrpe_pkg::WD_EARLY;
						restart = 1'b1;
					end
					else if (ms_tick && ms_q == SERV_MS - 10'h001)
					begin
						wd_d = wwrpe_pkg::WD_HOLD;
						restart = 1'b1;
					end
				end
				wwrpe_pkg::WD_SHUT:
				begin
					if (ms_tick && ms_q == wwrpe_pkg::SHUTDOWN_RESET_MS - 10'h001)
					begin
						wd_d = wwrpe_pkg::WD_EARLY;
						restart = 1'b1;
					end
				end
				default:
				begin
					wd_d = wwrpe_pkg::WD_OFF;
				end
			endcase
		end
		// Interval count clears on every restart
		if (restart || wd_d == wwrpe_pkg::WD_OFF)
		begin
			ms_d = 10'h000;
		end
		else
		begin
			ms_d = ms_q + {9'h000, ms_tick};
		end
		hold_cyc_d = (wd_q == wwrpe_pkg::WD_HOLD) ? hold_cyc_q + 24'h000001 : 24'h000000;
		// Reset released only while a window runs
		rst_out_b_d = (wd_d == wwrpe_pkg::WD_EARLY) || (wd_d == wwrpe_pkg::WD_SERV);
		service_open_d = (wd_d == wwrpe_pkg::WD_SERV);
	end

	// Watchdog registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wd_q <= wwrpe_pkg::WD_OFF;
			ms_q <= 10'h000;
			hold_cyc_q <= 24'h000000;
			rst_out_b_q <= 1'b0;
			service_open_q <= 1'b0;
		end
		else
		begin
			wd_q <= wd_d;
			ms_q <= ms_d;
			hold_cyc_q <= hold_cyc_d;
			rst_out_b_q <= rst_out_b_d;
			service_open_q <= service_open_d;
		end
	end

	// Port entry state
	wwrpe_pkg::wwrpe_entry_t ent_q;
	wwrpe_pkg::wwrpe_entry_t ent_d;
	logic [7:0] cyc_q; // System cycles since the enable falling edge
	logic [7:0] cyc_d;
	logic [2:0] osc_q; // Oscillator cycles counted in this state
	logic [2:0] osc_d;
	logic sleep_req_d;
	logic port_mode_d;

	// Next entry state: serial port, low power request or nothing
	always_comb
	begin
		ent_d = ent_q;
		cyc_d = cyc_q;
		osc_d = osc_q;
		sleep_req_d = 1'b0;
		case (ent_q)
			wwrpe_pkg::EN_IDLE:
			begin
				if (en_fall)
				begin
					ent_d = wwrpe_pkg::EN_WAIT;
					cyc_d = 8'h00;
					osc_d = 3'h0;
				end
			end
			wwrpe_pkg::EN_WAIT:
			begin
				if (pins_s_q.en)
				begin
					ent_d = wwrpe_pkg::EN_IDLE;
				end
				else if (tx_fall)
				begin
					// Only a fall inside the entry window opens the port
					if (cyc_q >= wwrpe_pkg::PORT_ENTRY_MIN_CYC &&
						cyc_q <= wwrpe_pkg::PORT_ENTRY_MAX_CYC)
					begin
						ent_d = wwrpe_pkg::EN_PORT;
						osc_d = 3'h0;
					end
					else
					begin
						ent_d = wwrpe_pkg::EN_DONE;
					end
				end
				else
				begin
					cyc_d = (cyc_q == wwrpe_pkg::CYC_SAT) ? cyc_q : cyc_q + 8'h01;
					if (!pins_s_q.tx)
					begin
						ent_d = wwrpe_pkg::EN_DONE;
					end
					else if (osc_tick)
					begin
						// Counted on the oscillator rate enable
						if (osc_q == wwrpe_pkg::STANDBY_ENTRY_TICKS - 3'h1)
						begin
							sleep_req_d = 1'b1;
							ent_d = wwrpe_pkg::EN_DONE;
						end
						else
						begin
							osc_d = osc_q + 3'h1;
						end
					end
				end
			end
			wwrpe_pkg::EN_PORT:
			begin
				// Enable toggles as the port clock; close only on a long idle
				if (pins_s_q.en && pins_s_q.tx)
				begin
					if (osc_tick)
					begin
						if (osc_q == wwrpe_pkg::PORT_IDLE_TICKS - 3'h1)
						begin
							ent_d = wwrpe_pkg::EN_IDLE;
						end
						else
						begin
							osc_d = osc_q + 3'h1;
						end
					end
				end
				else
				begin
					osc_d = 3'h0;
				end
			end
			wwrpe_pkg::EN_DONE:
			begin
				if (pins_s_q.en)
				begin
					ent_d = wwrpe_pkg::EN_IDLE;
				end
			end
			default:
			begin
				ent_d = wwrpe_pkg::EN_IDLE;
			end
		endcase
		port_mode_d = (ent_d == wwrpe_pkg::EN_PORT);
	end

	// Port entry registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ent_q <= wwrpe_pkg::EN_IDLE;
			cyc_q <= 8'h00;
			osc_q <= 3'h0;
			sleep_req_q <= 1'b0;
			port_mode_q <= 1'b0;
		end
		else
		begin
			ent_q <= ent_d;
			cyc_q <= cyc_d;
			osc_q <= osc_d;
			sleep_req_q <= sleep_req_d;
			port_mode_q <= port_mode_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_early_trig;
		wd_q == wwrpe_pkg::WD_EARLY && wd_trigger && pins_s_q.supply_ok && !shutdown_req;
	endsequence
	sequence s_serv_trig;
		wd_q == wwrpe_pkg::WD_SERV && wd_trigger && pins_s_q.supply_ok && !shutdown_req;
	endsequence
	sequence s_port_edge;
		ent_q == wwrpe_pkg::EN_WAIT && !pins_s_q.en && tx_fall &&
			cyc_q >= wwrpe_pkg::PORT_ENTRY_MIN_CYC && cyc_q <= wwrpe_pkg::PORT_ENTRY_MAX_CYC;
	endsequence

	chk_early_trig_reset: assert property (s_early_trig |=> !rst_out_b_q ##1 !rst_out_b_q)
		else $error("early trigger did not start a reset");
	chk_service_accept: assert property (s_serv_trig |=> rst_out_b_q &&
		ms_q == 10'h000 && wd_q == wwrpe_pkg::WD_EARLY)
		else $error("service trigger not accepted");
	chk_missed_window: assert property (wd_q == wwrpe_pkg::WD_SERV && !wd_trigger &&
		!shutdown_req && pins_s_q.supply_ok && ms_tick && ms_q == SERV_MS - 10'h001
		|=> !rst_out_b_q && wd_q == wwrpe_pkg::WD_HOLD)
		else $error("missed window did not reset");
	chk_hold_length: assert property (wd_q == wwrpe_pkg::WD_HOLD &&
		wd_d == wwrpe_pkg::WD_EARLY |-> hold_cyc_q == HOLD_CYC)
		else $error("reset hold length wrong");
	chk_shutdown_reset: assert property (wd_q == wwrpe_pkg::WD_SHUT |-> !rst_out_b_q
		and (ms_q < wwrpe_pkg::SHUTDOWN_RESET_MS))
		else $error("shutdown reset not held");
	chk_early_length: assert property (wd_q == wwrpe_pkg::WD_EARLY |->
		ms_q < EARLY_MS)
		else $error("early window overran");
	chk_port_entry: assert property (s_port_edge |=> port_mode_q ##1 port_mode_q)
		else $error("port entry not recognised");
	chk_standby_entry: assert property (ent_q == wwrpe_pkg::EN_WAIT && !pins_s_q.en &&
		!tx_fall && pins_s_q.tx && osc_tick && osc_q == 3'h4 |=> sleep_req_q ##1 !sleep_req_q)
		else $error("standby entry not requested");
	chk_undervolt_off: assert property (!pins_s_q.supply_ok |=> !rst_out_b_q &&
		!service_open_q)
		else $error("watchdog ran under undervoltage");

endmodule : wwrpe_top

/* File: wwrpe_mcu_model.sv */
`timescale 1ns/1ps
// Behavioural microcontroller driving the shared enable and transmit pins
module wwrpe_mcu_model (
	output logic en_pin,
	output logic tx_pin
);
	// Link step of the host, only running inside a frame
	localparam realtime LNK_NS = 400.0;

	// Both lines idle high
	initial
	begin
		en_pin = 1'b1;
		tx_pin = 1'b1;
	end

	// Enable falls; transmit falls after dly link steps when drop is set
	task automatic frame(input int dly, input bit drop);
		en_pin = 1'b0;
		#(dly * LNK_NS);
		if (drop)
		begin
			tx_pin = 1'b0;
			// Hold off five oscillator periods before any port clocking may start
			#(5.0 * wwrpe_pkg::OSC_DIV * wwrpe_pkg::CLK_NS);
		end
	endtask : frame

	// Ends the frame: transmit handed back high, then enable high
	task automatic idle();
		tx_pin = 1'b1;
		#(LNK_NS);
		en_pin = 1'b1;
	endtask : idle

endmodule : wwrpe_mcu_model

/* File: window_watchdog_reset_port_entry_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the watchdog, reset timing and port entry
module window_watchdog_reset_port_entry_tb_top;
	localparam int unsigned MSC = 20; // Shortened cycles per ms
	localparam int HOLD_C = 8 * MSC; // Reset hold, nominal choice
	localparam int WIN_C = 100 * MSC; // Each window at nominal scale
	localparam int SHUT_C = 500 * MSC; // Shutdown reset time
	localparam int OSC_C = 156; // Oscillator period in clocks

	logic clk_sys, rst_b, supply_ok, wd_trigger, shutdown_req;
	logic en_pin, tx_pin, rst_out_b_q, service_open_q, port_mode_q, sleep_req_q;
	int failures = 0;
	int checks = 0;
	int n;

	// Host model on the far side
	wwrpe_mcu_model i_mcu (.en_pin(en_pin), .tx_pin(tx_pin));

	// Device under test
	wwrpe_top #(.MS_CYC(MSC)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .supply_ok(supply_ok), .en_pin(en_pin),
		.tx_pin(tx_pin), .wd_trigger(wd_trigger), .shutdown_req(shutdown_req),
		.rst_out_b_q(rst_out_b_q), .service_open_q(service_open_q),
		.port_mode_q(port_mode_q), .sleep_req_q(sleep_req_q));

	// Clock at 50 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic test_done();
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	// Compares one output bit
	task automatic chk_bit(input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_bit

	// Compares a measured cycle count within a tolerance
	task automatic chk_cnt(input int exp, input int got, input int tol);
		checks++;
		if (got < exp - tol || got > exp + tol)
		begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_cnt

	// Counts clocks until reset (sel 0) or service flag (sel 1) reaches lvl
	task automatic cnt(input bit sel, input logic lvl, output int c);
		c = 0;
		while (((sel ? service_open_q : rst_out_b_q) !== lvl) && c < 30000)
		begin
			@(posedge clk_sys);
			#1;
			c++;
		end
	endtask : cnt

	// One-cycle trigger (sd 0) or shutdown request (sd 1)
	task automatic pulse(input bit sd);
		@(posedge clk_sys);
		wd_trigger <= !sd;
		shutdown_req <= sd;
		@(posedge clk_sys);
		wd_trigger <= 1'b0;
		shutdown_req <= 1'b0;
		#1;
	endtask : pulse

	// Service trigger accepted, window restarts each time
	task automatic t_service();
		cnt(1'b1, 1'b1, n);
		chk_cnt(WIN_C, n, 2);
		pulse(1'b0);
		chk_bit(1'b0, service_open_q);
		chk_bit(1'b1, rst_out_b_q);
		cnt(1'b1, 1'b1, n);
		chk_cnt(WIN_C, n, 2);
	endtask : t_service

	// Trigger inside the early window resets for the hold time
	task automatic t_early();
		pulse(1'b0);
		repeat (20) @(posedge clk_sys);
		pulse(1'b0);
		chk_bit(1'b0, rst_out_b_q);
		cnt(1'b0, 1'b1, n);
		chk_cnt(HOLD_C, n, 2);
	endtask : t_early

	// No trigger at all: reset at the end of the service window
	task automatic t_missed();
		cnt(1'b1, 1'b1, n);
		chk_cnt(WIN_C, n, 2);
		cnt(1'b0, 1'b0, n);
		chk_cnt(WIN_C, n, 2);
		cnt(1'b0, 1'b1, n);
		chk_cnt(HOLD_C, n, 2);
	endtask : t_missed

	// Temporary shutdown holds reset, then the early window follows
	task automatic t_shut();
		pulse(1'b1);
		chk_bit(1'b0, rst_out_b_q);
		cnt(1'b0, 1'b1, n);
		chk_cnt(SHUT_C, n, 2);
		cnt(1'b1, 1'b1, n);
		chk_cnt(WIN_C, n, 2);
	endtask : t_shut

	// Undervoltage forces reset; triggers ignored; full hold on return
	task automatic t_supply();
		@(posedge clk_sys);
		supply_ok <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		chk_bit(1'b0, rst_out_b_q);
		chk_bit(1'b0, service_open_q);
		pulse(1'b0);
		@(posedge clk_sys);
		supply_ok <= 1'b1;
		cnt(1'b0, 1'b1, n);
		chk_cnt(HOLD_C + 3, n, 3);
	endtask : t_supply

	// Port entry for a delay in link steps; expect entry or not
	task automatic t_port(input int dly, input logic exp);
		i_mcu.frame(dly, 1'b1);
		repeat (8) @(posedge clk_sys);
		#1;
		chk_bit(exp, port_mode_q);
		i_mcu.idle();
		repeat (2 * OSC_C + 40) @(posedge clk_sys);
		#1;
		chk_bit(1'b0, port_mode_q);
	endtask : t_port

	// Transmit kept high after enable falls: one sleep pulse
	task automatic t_sleep();
		i_mcu.frame(0, 1'b0);
		n = 0;
		while (sleep_req_q !== 1'b1 && n < 8 * OSC_C)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk_cnt(5 * OSC_C, n, OSC_C);
		@(posedge clk_sys);
		#1;
		chk_bit(1'b0, sleep_req_q);
		i_mcu.idle();
		repeat (2 * OSC_C + 40) @(posedge clk_sys);
	endtask : t_sleep

	// Watchdog against hangs
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		failures++;
		test_done();
	end

	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		supply_ok = 1'b1;
		wd_trigger = 1'b0;
		shutdown_req = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk_bit(1'b0, rst_out_b_q);
		cnt(1'b0, 1'b1, n);
		chk_cnt(HOLD_C + 3, n, 3);
		t_service();
		t_early();
		t_missed();
		t_shut();
		t_supply();
		t_port(10, 1'b1);
		t_port(1, 1'b0);
		t_port(30, 1'b0);
		t_sleep();
		test_done();
	end

endmodule : window_watchdog_reset_port_entry_tb_top
